// [design/tgu_prescaler.sv]
// Slow clock prescaler: turns slow clock rising edges into tick events.
`timescale 1ns/1ps
`include "tgu_defines.svh"

module tgu_prescaler #(
  parameter int CNT_W = 5
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic slow_clock, // Slow clock level, synchronous
  input wire logic run, // Low freezes the divider
  input wire logic [`TGU_DIV_W-1:0] prescaler_field, // Divisor code
  output logic tick // One-cycle pulse per tick rising edge
);

  logic slow_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] last_w;
  logic slow_rise;
  logic wrap;

  // Reserved codes fall back to the largest divisor
  assign last_w = (prescaler_field > `TGU_DIV_MAX) ? {CNT_W{1'b1}} :
                  CNT_W'((32'h1 << prescaler_field) - 32'h1);
  assign slow_rise = run && slow_clock && !slow_reg;
  assign wrap = slow_rise && (cnt_reg >= last_w);
  assign cnt_next = wrap ? '0 : (slow_rise ? cnt_reg + CNT_W'(1) : cnt_reg);
  assign tick = wrap;

  // Edge memory tracks the pin even in halt, so resume gives no stale edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slow_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      slow_reg <= slow_clock;
      cnt_reg <= cnt_next;
    end
  end

endmodule : tgu_prescaler

// [design/tgu_top.sv]
// Timing guard unit: register file, periodic timer, locks and watchdog.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "tgu_defines.svh"

module tgu_top #(
  parameter int TIMER_W = 16,
  parameter int WD_W = 8
) (
  input wire logic clock, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input tgu_pkg::tgu_req_t reg_req, // Register bus request
  output logic [`TGU_DATA_W-1:0] rd_data, // Read data, cycle after the read
  input wire logic slow_clock, // Slow clock level, synchronous
  input wire logic mode_low_power, // Power save or idle mode
  input wire logic mode_halt, // Halt mode, freezes the block
  output logic periodic_pulse, // Periodic pulse, also to the wakeup unit
  output logic timer_irq_line, // Timer interrupt, one-cycle pulse
  output logic watchdog_running, // Watchdog has been started
  output logic watchdog_reset // Watchdog error, device reset request
);

  // Configuration and timer state
  logic [`TGU_NUM_LOCKS-1:0] lock_reg;
  logic clock_select_reg;
  logic match_enable_reg;
  logic [`TGU_DIV_W-1:0] prescaler_reg;
  logic [TIMER_W-1:0] reload_reg;
  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;
  logic restart_reg;
  logic tc_reg;
  logic inte_reg;
  logic pulse_reg;
  logic irq_reg;
  logic [WD_W-1:0] count_load_reg;
  logic [`TGU_DATA_W-1:0] rd_data_reg;

  // Named lock and access wires
  logic lock_config;
  logic lock_prescaler;
  logic lock_reload;
  logic lock_count;
  logic active_ok;
  logic match_ok;

  // Address decode
  logic hit_config;
  logic hit_prescaler;
  logic hit_reload;
  logic hit_ctrl;
  logic hit_count;
  logic hit_match;

  // Accepted writes and reads
  logic wr_config;
  logic wr_prescaler;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_count;
  logic wr_match;
  logic rd_ctrl;
  logic [`TGU_DATA_W-1:0] rd_mux;
  logic [7:0] wdata_byte;

  // Timer and watchdog events
  logic tick;
  logic zero_hit;
  logic wd_clk_evt;
  logic wd_start;
  logic wd_service;
  logic wd_bad_key;
  logic [WD_W-1:0] wd_load_value;
  tgu_pkg::tgu_wd_state_t wd_state;
  logic wd_error;

  assign lock_config = lock_reg[`TGU_CFG_LOCK_CONFIG];
  assign lock_prescaler = lock_reg[`TGU_CFG_LOCK_PRESCALER];
  assign lock_reload = lock_reg[`TGU_CFG_LOCK_RELOAD];
  assign lock_count = lock_reg[`TGU_CFG_LOCK_COUNT];

  // Only the match register survives power save and idle
  assign active_ok = !mode_low_power && !mode_halt;
  assign match_ok = !mode_halt;

  // Address decode against the printed offsets
  assign hit_config = (reg_req.addr == `TGU_ADDR_CONFIG);
  assign hit_prescaler = (reg_req.addr == `TGU_ADDR_PRESCALER);
  assign hit_reload = (reg_req.addr == `TGU_ADDR_RELOAD);
  assign hit_ctrl = (reg_req.addr == `TGU_ADDR_CTRL);
  assign hit_count = (reg_req.addr == `TGU_ADDR_COUNT);
  assign hit_match = (reg_req.addr == `TGU_ADDR_MATCH);
  assign wdata_byte = reg_req.wdata[7:0];

  // Write qualification: locked or inaccessible registers drop writes
  assign wr_config = reg_req.wr && hit_config && active_ok && !lock_config;
  assign wr_prescaler = reg_req.wr && hit_prescaler && active_ok && !lock_prescaler;
  assign wr_reload = reg_req.wr && hit_reload && active_ok && !lock_reload;
  assign wr_ctrl = reg_req.wr && hit_ctrl && active_ok && !lock_reload;
  assign wr_count = reg_req.wr && hit_count && active_ok && !lock_count;
  assign wr_match = reg_req.wr && hit_match && match_ok;
  assign rd_ctrl = reg_req.rd && hit_ctrl && active_ok && !lock_reload;

  // Lock bits: set-only, one flop per bit
  generate
    for (genvar i = 0; i < `TGU_NUM_LOCKS; i++) begin : g_lock
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          lock_reg[i] <= 1'b0;
        end else if (wr_config && wdata_byte[i]) begin
          lock_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Watchdog clock select and service method
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clock_select_reg <= 1'b0;
      match_enable_reg <= 1'b0;
    end else if (wr_config) begin
      clock_select_reg <= wdata_byte[`TGU_CFG_CLOCK_SELECT];
      match_enable_reg <= wdata_byte[`TGU_CFG_MATCH_ENABLE];
    end
  end

  // Prescaler code; reserved codes are stored as written
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prescaler_reg <= '0;
    end else if (wr_prescaler) begin
      prescaler_reg <= wdata_byte[`TGU_DIV_W-1:0];
    end
  end

  // Reload value; the running count is left alone
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reload_reg <= `TGU_RELOAD_RST;
    end else if (wr_reload) begin
      reload_reg <= reg_req.wdata[TIMER_W-1:0];
    end
  end

  // Stored watchdog count, write-only to software
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_load_reg <= `TGU_COUNT_RST;
    end else if (wr_count) begin
      count_load_reg <= wdata_byte[WD_W-1:0];
    end
  end

  // Divider; halt stops it so every later stage freezes as well
  tgu_prescaler #(
    .CNT_W(5)
  ) u_prescaler (
    .clock(clock),
    .sys_rst(sys_rst),
    .slow_clock(slow_clock),
    .run(!mode_halt),
    .prescaler_field(prescaler_reg),
    .tick(tick)
  );

  // Periodic timer: restart first, then reload at zero, else count down
  assign count_next = !tick ? count_reg :
                      restart_reg ? reload_reg :
                      (count_reg == '0) ? reload_reg :
                      count_reg - TIMER_W'(1);
  // Reaching zero on a tick; a restart to zero would be reserved anyway
  assign zero_hit = tick && (count_next == '0) && (count_reg != '0);

  // Count register itself
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= `TGU_RELOAD_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // Restart request; a new write wins over the clearing tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      restart_reg <= 1'b0;
    end else if (wr_ctrl && wdata_byte[`TGU_CTRL_RESTART]) begin
      restart_reg <= 1'b1;
    end else if (tick) begin
      restart_reg <= 1'b0;
    end
  end

  // Interrupt enable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inte_reg <= 1'b0;
    end else if (wr_ctrl) begin
      inte_reg <= wdata_byte[`TGU_CTRL_INTE];
    end
  end

  // Terminal count: cleared by reading, a new zero in that cycle wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tc_reg <= 1'b0;
    end else if (zero_hit) begin
      tc_reg <= 1'b1;
    end else if (rd_ctrl) begin
      tc_reg <= 1'b0;
    end
  end

  // Periodic pulse level holds for one whole tick period
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulse_reg <= 1'b0;
    end else if (tick) begin
      pulse_reg <= zero_hit;
    end
  end

  // Interrupt pulse gated by the enable bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= zero_hit && inte_reg;
    end
  end

  // Watchdog clock: tick, or the rising edge of the periodic pulse
  assign wd_clk_evt = clock_select_reg ? tick : zero_hit;
  // Match writes count only while match servicing is on
  assign wd_start = wr_count || (wr_match && match_enable_reg);
  assign wd_service = (wr_count && !match_enable_reg) ||
                      (wr_match && match_enable_reg && wdata_byte == `TGU_MATCH_KEY);
  assign wd_bad_key = wr_match && match_enable_reg && (wdata_byte != `TGU_MATCH_KEY);
  assign wd_load_value = wr_count ? wdata_byte[WD_W-1:0] : count_load_reg;

  // Watchdog core
  tgu_wdog #(
    .CNT_W(WD_W)
  ) u_wdog (
    .clock(clock),
    .sys_rst(sys_rst),
    .wd_clk_evt(wd_clk_evt),
    .start(wd_start),
    .service(wd_service),
    .bad_key(wd_bad_key),
    .load_value(wd_load_value),
    .state(wd_state),
    .error(wd_error)
  );

  // Read mux; locked, write-only and unmapped reads give zero
  assign rd_mux = !active_ok ? '0 :
                  (hit_config && !lock_config) ?
                    {10'h000, match_enable_reg, clock_select_reg, lock_reg} :
                  (hit_prescaler && !lock_prescaler) ? {13'h0000, prescaler_reg} :
                  (hit_reload && !lock_reload) ? reload_reg :
                  (hit_ctrl && !lock_reload) ? {13'h0000, inte_reg, tc_reg, restart_reg} :
                  '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= reg_req.rd ? rd_mux : '0;
    end
  end

  // Outputs
  assign rd_data = rd_data_reg;
  assign periodic_pulse = pulse_reg;
  assign timer_irq_line = irq_reg;
  assign watchdog_running = (wd_state == tgu_pkg::TGU_WD_RUN);
  assign watchdog_reset = wd_error;

endmodule : tgu_top

// [design/tgu_wdog.sv]
// Watchdog core: 8-bit down counter, service checks and error latch.
`timescale 1ns/1ps

module tgu_wdog #(
  parameter int CNT_W = 8
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic wd_clk_evt, // Rising edge of selected watchdog clock
  input wire logic start, // Write that may start the watchdog
  input wire logic service, // Valid service request
  input wire logic bad_key, // Match register written with a wrong value
  input wire logic [CNT_W-1:0] load_value, // Value to load on start or service
  output tgu_pkg::tgu_wd_state_t state, // Idle or running
  output logic error // Sticky error, asks for device reset
);

  tgu_pkg::tgu_wd_state_t state_reg;
  tgu_pkg::tgu_wd_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic touched_reg;
  logic touched_next;
  logic err_reg;
  logic running;
  logic too_late;
  logic too_often;

  assign running = (state_reg == tgu_pkg::TGU_WD_RUN);
  // Expiry: counter would reach zero with no service this edge
  assign too_late = running && wd_clk_evt && !service && (cnt_reg <= CNT_W'(1));
  // Second service inside one watchdog clock cycle
  assign too_often = running && service && touched_reg && !wd_clk_evt;

  // State: only reset leaves the running state
  always_comb begin
    case (state_reg)
      tgu_pkg::TGU_WD_IDLE: state_next = start ? tgu_pkg::TGU_WD_RUN : tgu_pkg::TGU_WD_IDLE;
      tgu_pkg::TGU_WD_RUN: state_next = tgu_pkg::TGU_WD_RUN;
      default: state_next = tgu_pkg::TGU_WD_IDLE;
    endcase
  end

  // Counter and per-cycle service memory
  assign cnt_next = (!running && start) || (running && service) ? load_value :
                    (running && wd_clk_evt && cnt_reg != '0) ? cnt_reg - CNT_W'(1) :
                    cnt_reg;
  assign touched_next = (!running && start) || (running && service) ? 1'b1 :
                        wd_clk_evt ? 1'b0 : touched_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= tgu_pkg::TGU_WD_IDLE;
      cnt_reg <= '0;
      touched_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      touched_reg <= touched_next;
      err_reg <= err_reg || too_late || too_often || (running && bad_key);
    end
  end

  assign state = state_reg;
  assign error = err_reg;

endmodule : tgu_wdog

// [pkg/tgu_defines.svh]
// Constants for the timing guard unit: offsets, fields, reset values.
`ifndef TGU_DEFINES_SVH
`define TGU_DEFINES_SVH

// Bus widths
`define TGU_ADDR_W 24
`define TGU_DATA_W 16

// Register offsets
`define TGU_ADDR_CONFIG 24'hffff20
`define TGU_ADDR_PRESCALER 24'hffff22
`define TGU_ADDR_RELOAD 24'hffff24
`define TGU_ADDR_CTRL 24'hffff26
`define TGU_ADDR_COUNT 24'hffff28
`define TGU_ADDR_MATCH 24'hffff2a

// Config register fields
`define TGU_CFG_LOCK_CONFIG 0
`define TGU_CFG_LOCK_PRESCALER 1
`define TGU_CFG_LOCK_RELOAD 2
`define TGU_CFG_LOCK_COUNT 3
`define TGU_CFG_CLOCK_SELECT 4
`define TGU_CFG_MATCH_ENABLE 5
`define TGU_NUM_LOCKS 4

// Timer control register fields
`define TGU_CTRL_RESTART 0
`define TGU_CTRL_TC 1
`define TGU_CTRL_INTE 2

// Prescaler field
`define TGU_DIV_W 3
`define TGU_DIV_MAX 3'h5

// Reset values and service key
`define TGU_RELOAD_RST 16'hffff
`define TGU_COUNT_RST 8'h0f
`define TGU_MATCH_KEY 8'h5c

`endif

// [pkg/tgu_pkg.sv]
// Types shared by the timing guard unit modules.
`include "tgu_defines.svh"

package tgu_pkg;

  // One register bus request, one cycle long
  typedef struct packed {
    logic [`TGU_ADDR_W-1:0] addr;
    logic [`TGU_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tgu_req_t;

  // Watchdog state, one-hot
  typedef enum logic [1:0] {
    TGU_WD_IDLE = 2'b01,
    TGU_WD_RUN = 2'b10
  } tgu_wd_state_t;

endpackage : tgu_pkg

// [tb/tgu_top_checker.sv]
// Port-level assertions for the timing guard unit.
`timescale 1ns/1ps
`include "tgu_defines.svh"

module tgu_top_checker #(
  parameter int TIMER_W = 16,
  parameter int WD_W = 8
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Synchronous reset
  input tgu_pkg::tgu_req_t reg_req, // Register bus request
  input wire logic [`TGU_DATA_W-1:0] rd_data, // Read data
  input wire logic slow_clock, // Slow clock level
  input wire logic mode_low_power, // Low power mode
  input wire logic mode_halt, // Halt mode
  input wire logic periodic_pulse, // Periodic pulse
  input wire logic timer_irq_line, // Timer interrupt
  input wire logic watchdog_running, // Watchdog started
  input wire logic watchdog_reset // Watchdog error
);
  // One clock domain, so one default clock and disable
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_reset_quiet: assert property ($fell(sys_rst) |-> !watchdog_running && !watchdog_reset)
    else $error("watchdog outputs not clear after reset");
  a_run_sticky: assert property (watchdog_running |=> watchdog_running)
    else $error("watchdog stopped while running");
  a_error_sticky: assert property (watchdog_reset |=> watchdog_reset)
    else $error("device reset request dropped");
  a_idle_no_error: assert property (!watchdog_running |-> !watchdog_reset)
    else $error("error raised while watchdog idle");
  a_start_cause: assert property ($rose(watchdog_running) |-> $past(reg_req.wr) &&
    ($past(reg_req.addr) == `TGU_ADDR_COUNT || $past(reg_req.addr) == `TGU_ADDR_MATCH))
    else $error("watchdog started without a start write");
  a_irq_with_pulse: assert property (timer_irq_line |-> $rose(periodic_pulse))
    else $error("timer interrupt without periodic pulse");
  a_rd_idle_zero: assert property (!$past(reg_req.rd) |-> rd_data == 16'h0000)
    else $error("read data outside read answer cycle");
  a_wo_read_zero: assert property (reg_req.rd && (reg_req.addr == `TGU_ADDR_COUNT ||
    reg_req.addr == `TGU_ADDR_MATCH) |=> rd_data == 16'h0000)
    else $error("write-only register read back");
  a_lp_read_zero: assert property ((mode_low_power || mode_halt) && reg_req.rd
    |=> rd_data == 16'h0000)
    else $error("register readable outside active mode");
  a_halt_freeze: assert property (mode_halt && $past(mode_halt)
    |-> $stable(periodic_pulse) && !timer_irq_line)
    else $error("timer moved during halt");
endmodule : tgu_top_checker

// [tb/tgu_top_test.sv]
// Self-checking bench for the timing guard unit.
`timescale 1ns/1ps
`include "tgu_defines.svh"

module tgu_top_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  tgu_pkg::tgu_req_t reg_req = '0;
  logic [15:0] rd_data;
  logic slow_clock = 1'b0;
  logic [1:0] slow_div = 2'h0;
  logic mode_low_power = 1'b0;
  logic mode_halt = 1'b0;
  logic periodic_pulse, timer_irq_line, watchdog_running, watchdog_reset;
  int bad_count = 0;
  int n_checks = 0;
  int irq_count = 0;

  tgu_top i_dut (.clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .rd_data(rd_data),
    .slow_clock(slow_clock), .mode_low_power(mode_low_power), .mode_halt(mode_halt),
    .periodic_pulse(periodic_pulse), .timer_irq_line(timer_irq_line),
    .watchdog_running(watchdog_running), .watchdog_reset(watchdog_reset));

  // 50 MHz system clock
  initial begin
    forever #10 clock = ~clock;
  end

  // Slow clock at a quarter rate, so one tick per 4 clocks at code 0
  always @(posedge clock) begin
    slow_div <= slow_div + 2'h1;
    slow_clock <= slow_div[1];
    if (timer_irq_line === 1'b1) irq_count <= irq_count + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus cycles: one-cycle strobes driven just after the edge
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req <= '0;
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req <= '0;
    #1;
    chk(what, exp, rd_data);
  endtask : rd

  task automatic wd_chk(input int w, input logic [15:0] exp, input string what);
    repeat (w) @(posedge clock);
    #1;
    chk(what, exp, {14'h0, watchdog_running, watchdog_reset});
  endtask : wd_chk

  task automatic do_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset

  // Bounded wait for a pulse level, counting cycles
  task automatic wait_lvl(input logic v, inout int n);
    int k;
    k = 0;
    while (periodic_pulse !== v && k < 3000) begin
      @(posedge clock);
      #1;
      k++;
      n++;
    end
  endtask : wait_lvl

  task automatic measure(output int n);
    int k;
    k = 0;
    wait_lvl(1'b0, k);
    wait_lvl(1'b1, k);
    n = 0;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
  endtask : measure

  task automatic t_reset_values;
    rd(`TGU_ADDR_CONFIG, 16'h0000, "config");
    rd(`TGU_ADDR_PRESCALER, 16'h0000, "prescaler");
    rd(`TGU_ADDR_RELOAD, 16'hffff, "reload");
    rd(`TGU_ADDR_COUNT, 16'h0000, "count readback");
    rd(24'hffff2c, 16'h0000, "unmapped");
  endtask : t_reset_values

  task automatic t_timer;
    int n;
    int i0;
    wr(`TGU_ADDR_RELOAD, 16'h0002);
    wr(`TGU_ADDR_CTRL, 16'h0005);
    for (int c = 0; c < 6; c++) begin
      wr(`TGU_ADDR_PRESCALER, 16'(c));
      measure(n);
      measure(n);
      chk("period per code", 16'(12 << c), 16'(n));
    end
    wr(`TGU_ADDR_PRESCALER, 16'h0000);
    measure(n);
    rd(`TGU_ADDR_CTRL, 16'h0006, "ctrl after zero");
    i0 = irq_count;
    measure(n);
    // The counter logs an interrupt one edge after it shows
    repeat (2) @(posedge clock);
    chk("irqs enabled", 16'h0002, 16'(irq_count - i0));
    wr(`TGU_ADDR_CTRL, 16'h0000);
    i0 = irq_count;
    measure(n);
    chk("irqs disabled", 16'h0000, 16'(irq_count - i0));
    // Let the reload pass so the new value lands mid-period
    repeat (5) @(posedge clock);
    wr(`TGU_ADDR_RELOAD, 16'h0005);
    n = 0;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    chk("old count kept", 16'h0001, {15'h0, n < 12});
    measure(n);
    chk("new period", 16'h0018, 16'(n));
    repeat (10) @(posedge clock);
    wr(`TGU_ADDR_CTRL, 16'h0001);
    n = 0;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    chk("restart delays", 16'h0001, {15'h0, n > 18});
  endtask : t_timer

  task automatic t_modes;
    int n;
    wr(`TGU_ADDR_CONFIG, 16'h0006);
    wr(`TGU_ADDR_PRESCALER, 16'h0003);
    rd(`TGU_ADDR_PRESCALER, 16'h0000, "locked prescaler");
    rd(`TGU_ADDR_RELOAD, 16'h0000, "locked reload");
    wr(`TGU_ADDR_CONFIG, 16'h0000);
    rd(`TGU_ADDR_CONFIG, 16'h0006, "lock bits kept");
    do_reset();
    rd(`TGU_ADDR_CTRL, 16'h0000, "restart clear");
    @(posedge clock);
    mode_low_power <= 1'b1;
    wr(`TGU_ADDR_RELOAD, 16'h0009);
    rd(`TGU_ADDR_RELOAD, 16'h0000, "reload in low power");
    @(posedge clock);
    mode_low_power <= 1'b0;
    rd(`TGU_ADDR_RELOAD, 16'hffff, "reload after low power");
    wr(`TGU_ADDR_RELOAD, 16'h0002);
    wr(`TGU_ADDR_CTRL, 16'h0001);
    measure(n);
    @(posedge clock);
    mode_halt <= 1'b1;
    repeat (100) @(posedge clock);
    chk("pulse frozen", 16'h0001, {15'h0, periodic_pulse});
    mode_halt <= 1'b0;
    measure(n);
    chk("period after halt", 16'h000c, 16'(n));
    do_reset();
  endtask : t_modes

  task automatic t_watchdog;
    wr(`TGU_ADDR_MATCH, 16'h005b);
    wd_chk(2, 16'h0000, "match ignored");
    wr(`TGU_ADDR_COUNT, 16'h0010);
    wd_chk(2, 16'h0002, "started by count");
    wr(`TGU_ADDR_COUNT, 16'h0010);
    wd_chk(2, 16'h0003, "too often");
    do_reset();
    wd_chk(1, 16'h0000, "reset stops");
    wr(`TGU_ADDR_CONFIG, 16'h0010);
    wr(`TGU_ADDR_COUNT, 16'h0003);
    wd_chk(4, 16'h0002, "not yet late");
    wd_chk(30, 16'h0003, "late on tick");
    do_reset();
    wr(`TGU_ADDR_RELOAD, 16'h0001);
    wr(`TGU_ADDR_CTRL, 16'h0001);
    wr(`TGU_ADDR_COUNT, 16'h0004);
    wd_chk(17, 16'h0002, "pulse clock slower");
    wd_chk(30, 16'h0003, "late on pulse");
    do_reset();
    wr(`TGU_ADDR_CONFIG, 16'h0030);
    wr(`TGU_ADDR_COUNT, 16'h0010);
    repeat (8) begin
      repeat (10) @(posedge clock);
      wr(`TGU_ADDR_MATCH, 16'h005c);
    end
    wd_chk(10, 16'h0002, "key services");
    wr(`TGU_ADDR_MATCH, 16'h005b);
    wd_chk(2, 16'h0003, "wrong key");
    do_reset();
    wr(`TGU_ADDR_CONFIG, 16'h0020);
    wr(`TGU_ADDR_COUNT, 16'h0010);
    wr(`TGU_ADDR_MATCH, 16'h005c);
    wd_chk(2, 16'h0003, "two services in one count");
  endtask : t_watchdog

  // Main sequence after the initial reset
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_values();
    t_timer();
    t_modes();
    t_watchdog();
    report_and_stop();
  end

  // Hang guard, well beyond the roughly 4k cycles the tests need
  initial begin
    #1000000;
    bad_count++;
    report_and_stop();
  end
endmodule : tgu_top_test

bind tgu_top tgu_top_checker #(.TIMER_W(TIMER_W), .WD_W(WD_W)) i_chk (.clock(clock),
  .sys_rst(sys_rst), .reg_req(reg_req), .rd_data(rd_data), .slow_clock(slow_clock),
  .mode_low_power(mode_low_power), .mode_halt(mode_halt), .periodic_pulse(periodic_pulse),
  .timer_irq_line(timer_irq_line), .watchdog_running(watchdog_running),
  .watchdog_reset(watchdog_reset));
